// ==== include/uarx_defines.vh ====
// register map, field positions and reset values of the serial port block
`ifndef UARX_DEFINES_VH
`define UARX_DEFINES_VH
// register indices, byte address is four times the index
`define UARX_IDX_CONTROL_A  8'h00
`define UARX_IDX_CONTROL_B  8'h04
`define UARX_IDX_DBGCTRL    8'h08
`define UARX_IDX_BAUD       8'h0A
`define UARX_IDX_IRQ_CLR    8'h0C
`define UARX_IDX_IRQ_SET    8'h0D
`define UARX_IDX_IRQ_FLAGS  8'h0E
`define UARX_IDX_STATUS     8'h10
`define UARX_IDX_DATA       8'h18
// control_a fields
`define UARX_A_SOFT_RESET   0
`define UARX_A_ENABLE       1
`define UARX_A_MODE_LO      2
`define UARX_A_MODE_HI      4
`define UARX_A_KEEP_RUN     7
`define UARX_A_TXPO         16
`define UARX_A_RXPO_LO      20
`define UARX_A_RXPO_HI      21
`define UARX_A_FORM_LO      24
`define UARX_A_FORM_HI      27
`define UARX_A_CMODE        28
`define UARX_A_CPOL         29
`define UARX_A_DORD         30
`define UARX_MODE_INTERNAL  3'h1
`define UARX_FORM_PARITY    4'h1
// control_b fields
`define UARX_B_CHSIZE_LO    0
`define UARX_B_CHSIZE_HI    2
`define UARX_B_SBMODE       6
`define UARX_B_PAR_ODD      13
`define UARX_B_TX_ON        16
`define UARX_B_RX_ON        17
// interrupt flag bits
`define UARX_F_HOLD_EMPTY   0
`define UARX_F_TX_DONE      1
`define UARX_F_RX_DONE      2
// status bits
`define UARX_S_PAR_ERR      0
`define UARX_S_FRAME_ERR    1
`define UARX_S_OVERFLOW     2
`define UARX_S_SYNC_BUSY    15
// oversampling points
`define UARX_OVS_S1         4'h7
`define UARX_OVS_S2         4'h8
`define UARX_OVS_MID        4'h9
`define UARX_OVS_LAST       4'hF
`define UARX_RESET_WORD     32'h0000_0000
`endif

// ==== rtl/uarx_top.v ====
// asynchronous serial port: clock and data recovery, parity, irq, sleep and sync
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "uarx_defines.vh"
// Function
// - receiver aligns frames to its baud clock and filters each bit against noise
// - receiver tolerates incoming rates from slow to fast ratio of its baud
// - parity generated and checked only when frame format is the parity code
// - even mode: parity bit high when an odd count of data bits are one
// - odd mode: parity bit high when an even count of data bits are one
// - received parity compared with computed parity, mismatch sets parity error
// - three flags kept: receive complete, transmit complete, transmit data empty
// - one to enable-set enables, one to enable-clear disables, zeros do nothing
// - request asserted while the port is enabled and any flag and its enable are both set
// - all three sources share one request line
// - internal clock and keep-running: clock stays on in sleep, any irq wakes
// - external clock and keep-running: receive complete can wake
// - keep-running clear: clock stops after transfer ends, completion still wakes
// - keep-running clear, external clock: reception discarded during sleep
// - sync-busy set at once on a synchronized write, cleared when done
// - synchronized write during busy stalls the bus and completes later
// - soft reset, enable, receiver and transmitter enable writes are synchronized
// - error flags stay until written one, and clear when receiver disabled
// - transmit complete set when the last bit leaves and nothing is pending
// - after the first stop bit the character enters a two-entry buffer
module uarx_top #(
  parameter SYNC_CYCLES = 4'h3
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // serial line
  input  wire        rxd,
  output reg         txd,
  // system
  input  wire        sleep_active,
  output wire        core_clock_run,
  output wire        wake_request,
  output wire        irq
);
  localparam RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3, RX_STOP = 3'h4;
  localparam TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2, TX_PAR = 3'h3, TX_STOP = 3'h4;

  function [3:0] char_bits;
    input [2:0] sz;
    begin
      case (sz)
        3'h1:    char_bits = 4'h9;
        3'h5:    char_bits = 4'h5;
        3'h6:    char_bits = 4'h6;
        3'h7:    char_bits = 4'h7;
        default: char_bits = 4'h8;
      endcase
    end
  endfunction

  function maj3;
    input [2:0] v;
    begin
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    end
  endfunction

  // keeps only the character bits; parity shows in data only with nine-bit characters
  function [8:0] char_mask;
    input [3:0] n;
    begin
      char_mask = (9'h1 << n) - 9'h1;
    end
  endfunction

  // bus decode
  wire [7:0]  idx      = paddr[9:2];
  wire        in_range = (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'h0);
  wire        hit_a    = in_range && idx == `UARX_IDX_CONTROL_A;
  wire        hit_b    = in_range && idx == `UARX_IDX_CONTROL_B;
  wire        mapped   = hit_a || hit_b || (in_range && (idx == `UARX_IDX_DBGCTRL ||
                         idx == `UARX_IDX_BAUD || idx == `UARX_IDX_IRQ_CLR ||
                         idx == `UARX_IDX_IRQ_SET || idx == `UARX_IDX_IRQ_FLAGS ||
                         idx == `UARX_IDX_STATUS || idx == `UARX_IDX_DATA));
  reg  [3:0]  sync_cnt;
  wire        sync_busy = (sync_cnt != 4'h0);
  wire        stall     = pwrite && (hit_a || hit_b) && sync_busy;
  wire        access    = psel && penable;
  assign pready  = !(access && stall);
  assign pslverr = access && !mapped;
  wire        done  = access && !stall && mapped;
  wire        wr    = done && pwrite;
  wire        rd    = done && !pwrite;

  // register state
  reg  [31:0] ctrl_a;
  reg  [31:0] ctrl_b;
  reg         dbg_stop;
  reg  [15:0] baud;
  reg  [2:0]  irq_en;
  reg         core_en, core_rx_on, core_tx_on;
  reg         pend_en, pend_rx_on, pend_tx_on, pend_soft_reset;
  wire        soft_rst = (sync_cnt == 4'h1) && pend_soft_reset;
  wire        locked   = ctrl_a[`UARX_A_ENABLE];
  wire [2:0]  mode     = ctrl_a[`UARX_A_MODE_HI:`UARX_A_MODE_LO];
  wire        internal = (mode == `UARX_MODE_INTERNAL);
  wire        keep_run = ctrl_a[`UARX_A_KEEP_RUN];
  wire        par_on   = (ctrl_a[`UARX_A_FORM_HI:`UARX_A_FORM_LO] == `UARX_FORM_PARITY);
  wire        lsb_first = ctrl_a[`UARX_A_DORD];
  wire        par_odd  = ctrl_b[`UARX_B_PAR_ODD];
  wire [3:0]  nbits    = char_bits(ctrl_b[`UARX_B_CHSIZE_HI:`UARX_B_CHSIZE_LO]);

  // protected fields only change while disabled; sync bits always go through the counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a <= `UARX_RESET_WORD; ctrl_b <= `UARX_RESET_WORD;
      dbg_stop <= 1'b0; baud <= 16'h0; irq_en <= 3'h0;
      core_en <= 1'b0; core_rx_on <= 1'b0; core_tx_on <= 1'b0;
      pend_en <= 1'b0; pend_rx_on <= 1'b0; pend_tx_on <= 1'b0; pend_soft_reset <= 1'b0;
      sync_cnt <= 4'h0;
    end else if (soft_rst) begin
      ctrl_a <= `UARX_RESET_WORD; ctrl_b <= `UARX_RESET_WORD;
      baud <= 16'h0; irq_en <= 3'h0;
      core_en <= 1'b0; core_rx_on <= 1'b0; core_tx_on <= 1'b0;
      pend_en <= 1'b0; pend_rx_on <= 1'b0; pend_tx_on <= 1'b0; pend_soft_reset <= 1'b0;
      sync_cnt <= 4'h0;
    end else begin
      if (sync_cnt == 4'h1) begin
        core_en    <= pend_en;
        core_rx_on <= pend_rx_on;
        core_tx_on <= pend_tx_on;
      end
      if (sync_busy)
        sync_cnt <= sync_cnt - 4'h1;
      if (wr && hit_a) begin
        if (!locked)
          ctrl_a <= pwdata & 32'h7F31_00FC;
        ctrl_a[`UARX_A_ENABLE] <= pwdata[`UARX_A_ENABLE];
        ctrl_a[`UARX_A_SOFT_RESET] <= pwdata[`UARX_A_SOFT_RESET];
        pend_en         <= pwdata[`UARX_A_ENABLE];
        pend_soft_reset <= pwdata[`UARX_A_SOFT_RESET];
        sync_cnt   <= SYNC_CYCLES;
      end
      if (wr && hit_b) begin
        if (!locked)
          ctrl_b <= pwdata & 32'h0000_2047;
        ctrl_b[`UARX_B_TX_ON] <= pwdata[`UARX_B_TX_ON];
        ctrl_b[`UARX_B_RX_ON] <= pwdata[`UARX_B_RX_ON];
        pend_tx_on <= pwdata[`UARX_B_TX_ON];
        pend_rx_on <= pwdata[`UARX_B_RX_ON];
        sync_cnt  <= SYNC_CYCLES;
      end
      if (wr && idx == `UARX_IDX_DBGCTRL)
        dbg_stop <= pwdata[0];
      if (wr && idx == `UARX_IDX_BAUD && !locked)
        baud <= pwdata[15:0];
      if (wr && idx == `UARX_IDX_IRQ_SET)
        irq_en <= irq_en | pwdata[2:0];
      else if (wr && idx == `UARX_IDX_IRQ_CLR)
        irq_en <= irq_en & ~pwdata[2:0];
    end
  end

  // fractional baud generator: carry out is the sixteen-times sample tick
  reg  [15:0] baud_acc;
  wire [16:0] baud_sum = {1'b0, baud_acc} + (17'h1_0000 - {1'b0, baud});
  wire        tick     = baud_sum[16] && core_en;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      baud_acc <= 16'h0;
    else if (!core_en || soft_rst)
      baud_acc <= 16'h0;
    else
      baud_acc <= baud_sum[15:0];
  end

  // receive line, two flops before any use
  reg rx_m, rx_s, rx_prev;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_m <= 1'b1; rx_s <= 1'b1; rx_prev <= 1'b1;
    end else begin
      rx_m <= rxd; rx_s <= rx_m; rx_prev <= rx_s;
    end
  end

  // receiver
  reg  [2:0]  rx_st;
  reg  [3:0]  rx_ovs, rx_idx;
  reg  [2:0]  rx_vote;
  reg  [8:0]  rx_sh;
  reg  [8:0]  rx_buf0, rx_buf1;
  reg  [1:0]  rx_cnt;
  reg         par_err, frame_err, rx_ovf;
  wire        rx_drop = sleep_active && !keep_run && !internal;
  wire        rx_bit  = maj3({rx_vote[1:0], rx_s});
  wire        rx_pop  = rd && idx == `UARX_IDX_DATA && rx_cnt != 2'h0;
  wire        clr_st  = wr && idx == `UARX_IDX_STATUS;
  wire [3:0]  rx_pos  = lsb_first ? rx_idx : nbits - 4'h1 - rx_idx;
  wire        rx_fin  = tick && rx_st == RX_STOP && rx_ovs == `UARX_OVS_MID;
  wire        rx_parity_error_flag = par_on && (^(rx_sh & char_mask(nbits)) ^ par_odd ^ rx_sh[8]);
  reg  [8:0]  next_sh;
  always @* begin
    next_sh = rx_sh;
    if (rx_st == RX_DATA)
      next_sh[rx_pos] = rx_bit;
    else if (rx_st == RX_PAR)
      next_sh[8] = rx_bit;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= RX_IDLE; rx_ovs <= 4'h0; rx_idx <= 4'h0; rx_vote <= 3'h0; rx_sh <= 9'h0;
      rx_buf0 <= 9'h0; rx_buf1 <= 9'h0; rx_cnt <= 2'h0;
      par_err <= 1'b0; frame_err <= 1'b0; rx_ovf <= 1'b0;
    end else if (soft_rst || !core_rx_on || !core_en) begin
      rx_st <= RX_IDLE; rx_cnt <= 2'h0;
      par_err <= 1'b0; frame_err <= 1'b0; rx_ovf <= 1'b0;
    end else begin
      if (rx_st == RX_IDLE) begin
        if (rx_prev && !rx_s && !rx_drop) begin
          rx_st <= RX_START; rx_ovs <= 4'h0; rx_idx <= 4'h0;
        end
      end else if (tick) begin
        rx_ovs <= rx_ovs + 4'h1;
        if (rx_ovs == `UARX_OVS_S1 || rx_ovs == `UARX_OVS_S2)
          rx_vote <= {rx_vote[1:0], rx_s};
        if (rx_ovs == `UARX_OVS_MID) begin
          // majority of three filters spikes shorter than two samples
          rx_sh <= next_sh;
          if (rx_st == RX_START && rx_bit)
            rx_st <= RX_IDLE;
          if (rx_st == RX_STOP)
            rx_st <= RX_IDLE;
        end
        if (rx_ovs == `UARX_OVS_LAST) begin
          if (rx_st == RX_START)
            rx_st <= RX_DATA;
          else if (rx_st == RX_DATA) begin
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == nbits - 4'h1)
              rx_st <= par_on ? RX_PAR : RX_STOP;
          end else if (rx_st == RX_PAR)
            rx_st <= RX_STOP;
        end
      end
      // pop and push may meet; with two held, the new frame replaces the second slot and the popped one stays in front
      if (rx_fin && !(rx_cnt == 2'h2 && !rx_pop)) begin
        if (rx_cnt == 2'h0 || (rx_cnt == 2'h1 && rx_pop))
          rx_buf0 <= rx_sh;
        else
          rx_buf1 <= rx_sh;
      end else if (rx_pop)
        rx_buf0 <= rx_buf1;
      if (rx_fin && !rx_pop && rx_cnt != 2'h2)
        rx_cnt <= rx_cnt + 2'h1;
      else if (rx_pop && !rx_fin)
        rx_cnt <= rx_cnt - 2'h1;
      // error flags: a new event wins over a software clear
      if (rx_fin && rx_parity_error_flag)
        par_err <= 1'b1;
      else if (clr_st && pwdata[`UARX_S_PAR_ERR])
        par_err <= 1'b0;
      if (rx_fin && !rx_bit)
        frame_err <= 1'b1;
      else if (clr_st && pwdata[`UARX_S_FRAME_ERR])
        frame_err <= 1'b0;
      if (rx_fin && rx_cnt == 2'h2 && !rx_pop)
        rx_ovf <= 1'b1;
      else if (clr_st && pwdata[`UARX_S_OVERFLOW])
        rx_ovf <= 1'b0;
    end
  end

  // transmitter
  reg  [2:0]  tx_st;
  reg  [3:0]  tx_ovs, tx_idx;
  reg  [8:0]  tx_hold, tx_sh;
  reg         hold_full, tx_done, tx_stop2;
  wire        tx_load  = wr && idx == `UARX_IDX_DATA;
  wire        txc_clr  = wr && idx == `UARX_IDX_IRQ_FLAGS && pwdata[`UARX_F_TX_DONE];
  wire [3:0]  tx_pos   = lsb_first ? tx_idx : nbits - 4'h1 - tx_idx;
  wire        tx_par   = ^(tx_sh & char_mask(nbits)) ^ par_odd;
  wire        tx_go    = core_en && core_tx_on && hold_full;
  wire        bit_end  = tick && tx_ovs == `UARX_OVS_LAST;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st <= TX_IDLE; tx_ovs <= 4'h0; tx_idx <= 4'h0; tx_hold <= 9'h0; tx_sh <= 9'h0;
      hold_full <= 1'b0; tx_done <= 1'b0; tx_stop2 <= 1'b0; txd <= 1'b1;
    end else if (soft_rst || !core_en) begin
      tx_st <= TX_IDLE; hold_full <= 1'b0; tx_done <= 1'b0; txd <= 1'b1;
    end else begin
      if (tx_load) begin
        tx_hold <= pwdata[8:0]; hold_full <= 1'b1;
      end
      if (tick)
        tx_ovs <= tx_ovs + 4'h1;
      case (tx_st)
        TX_IDLE: begin
          txd <= 1'b1;
          if (tx_go && tick) begin
            tx_sh <= tx_hold; hold_full <= tx_load; tx_st <= TX_START;
            tx_ovs <= 4'h0; txd <= 1'b0;
          end
        end
        TX_START: if (bit_end) begin
          tx_st <= TX_DATA; tx_idx <= 4'h0; txd <= tx_sh[lsb_first ? 4'h0 : nbits - 4'h1];
        end
        TX_DATA: if (bit_end) begin
          tx_idx <= tx_idx + 4'h1;
          if (tx_idx == nbits - 4'h1) begin
            tx_st <= par_on ? TX_PAR : TX_STOP;
            txd <= par_on ? tx_par : 1'b1;
            tx_stop2 <= ctrl_b[`UARX_B_SBMODE];
          end else
            txd <= tx_sh[lsb_first ? tx_idx + 4'h1 : tx_pos - 4'h1];
        end
        TX_PAR: if (bit_end) begin
          tx_st <= TX_STOP; txd <= 1'b1;
        end
        TX_STOP: if (bit_end) begin
          tx_stop2 <= 1'b0;
          if (!tx_stop2) begin
            if (tx_go) begin
              tx_sh <= tx_hold; hold_full <= tx_load; tx_st <= TX_START; txd <= 1'b0;
            end else
              tx_st <= TX_IDLE;
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
      // completion wins over a same-cycle clear; new data also withdraws it
      if (tx_st == TX_STOP && bit_end && !tx_stop2 && !tx_go)
        tx_done <= 1'b1;
      else if (txc_clr || tx_load)
        tx_done <= 1'b0;
    end
  end

  // interrupt, sleep and wake
  wire [2:0] flags = {rx_cnt != 2'h0, tx_done, !hold_full};
  wire [2:0] pend  = flags & irq_en;
  wire       busy_xfer = (tx_st != TX_IDLE) || (rx_st != RX_IDLE);
  assign irq = core_en && (|pend);
  assign core_clock_run = core_en && (!sleep_active || (keep_run && internal) || busy_xfer);
  assign wake_request = sleep_active && core_en && (
      (keep_run && internal && (|pend)) ||
      (keep_run && !internal && pend[`UARX_F_RX_DONE]) ||
      (!keep_run && (pend[`UARX_F_TX_DONE] || pend[`UARX_F_RX_DONE])));

  // read data registered in the setup cycle; rx slots do not move before the access ends
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable) begin
      prdata <= 32'h0;
      if (hit_a)
        prdata <= ctrl_a;
      else if (hit_b)
        prdata <= ctrl_b;
      else if (in_range && idx == `UARX_IDX_DBGCTRL)
        prdata <= {31'h0, dbg_stop};
      else if (in_range && idx == `UARX_IDX_BAUD)
        prdata <= {16'h0, baud};
      else if (in_range && (idx == `UARX_IDX_IRQ_SET || idx == `UARX_IDX_IRQ_CLR))
        prdata <= {29'h0, irq_en};
      else if (in_range && idx == `UARX_IDX_IRQ_FLAGS)
        prdata <= {29'h0, flags};
      else if (in_range && idx == `UARX_IDX_STATUS)
        prdata <= {16'h0, sync_busy, 12'h0, rx_ovf, frame_err, par_err};
      else if (in_range && idx == `UARX_IDX_DATA)
        prdata <= {23'h0, rx_buf0 & char_mask(nbits)};
    end
  end
endmodule

// ==== testbench/uarx_remote.sv ====
// remote serial end: frame sender and frame catcher on the line
`timescale 1ns/1ps
module uarx_remote #(
  parameter real BIT_NS = 320.0
) (
  // serial line
  input  wire txd,
  output reg  rxd
);
  logic [7:0] got_data;
  logic       got_par;
  int         got_cnt = 0;
  initial rxd = 1'b1;
  // lsb first, optional parity, stop level picked per frame
  task send(input logic [7:0] d, input logic pen, input logic pb, input logic stp, input real bt);
    rxd = 1'b0;
    #(bt);
    for (int i = 0; i < 8; i++) begin
      rxd = d[i];
      #(bt);
    end
    if (pen) begin
      rxd = pb;
      #(bt);
    end
    rxd = stp;
    #(bt);
    rxd = 1'b1;
    #(bt);
  endtask
  // only parity frames expected from the port
  always begin
    @(negedge txd);
    #(BIT_NS * 1.5);
    for (int i = 0; i < 8; i++) begin
      got_data[i] = txd;
      #(BIT_NS);
    end
    got_par = txd;
    #(BIT_NS);
    got_cnt++;
  end
endmodule

// ==== testbench/uarx_top_properties.sv ====
// concurrent checks on bus stalls, sync busy and irq of the serial port
`timescale 1ns/1ps
`include "uarx_defines.vh"
module uarx_top_properties #(
  parameter SYNC_CYCLES = 4'h3
) (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  // system
  input wire        irq
);
  localparam logic [31:0] A_CA = 4 * `UARX_IDX_CONTROL_A;
  localparam logic [31:0] A_CB = 4 * `UARX_IDX_CONTROL_B;
  localparam logic [31:0] A_ST = 4 * `UARX_IDX_STATUS;
  localparam logic [31:0] A_SET = 4 * `UARX_IDX_IRQ_SET;
  localparam logic [31:0] A_CLR = 4 * `UARX_IDX_IRQ_CLR;
  logic [4:0] sync_age;
  logic [2:0] mask_sh;
  wire        take = psel && penable && pready;
  wire        st_rd = psel && !penable && !pwrite && paddr == A_ST;
  // shadow mask may stay set after soft reset; only used as an upper bound
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_age <= 5'h1F;
      mask_sh  <= 3'h0;
    end else begin
      if (take && pwrite && (paddr == A_CA || paddr == A_CB))
        sync_age <= 5'h00;
      else if (sync_age != 5'h1F)
        sync_age <= sync_age + 5'h01;
      if (take && pwrite && paddr == A_SET)
        mask_sh <= mask_sh | pwdata[2:0];
      else if (take && pwrite && paddr == A_CLR)
        mask_sh <= mask_sh & ~pwdata[2:0];
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_read_no_stall: assert property (psel && penable && !pwrite |-> pready)
    else $error("read access was stalled");
  a_stall_sync_only: assert property (!pready |-> pwrite && (paddr == A_CA || paddr == A_CB))
    else $error("stall on a write that needs no sync");
  a_stall_needs_busy: assert property (psel && penable && !pready |-> sync_age <= SYNC_CYCLES)
    else $error("stall without a sync in flight");
  a_stall_bounded: assert property (psel && penable && !pready |-> ##[1:16] pready)
    else $error("stalled write never completed");
  a_busy_at_once: assert property (st_rd && sync_age == 0 && $past(paddr) == A_CA |=> prdata[15])
    else $error("sync busy not set right after control write");
  a_busy_clears: assert property (st_rd && sync_age > SYNC_CYCLES + 1 |=> !prdata[15])
    else $error("sync busy still set after sync time");
  a_irq_needs_en: assert property (irq |-> mask_sh != 3'h0)
    else $error("irq with no source enabled");
  a_irq_off_clear: assert property (take && pwrite && paddr == A_CLR && pwdata[2:0] == 3'h7 |=> !irq)
    else $error("irq stayed after all enables cleared");
  c_stall: cover property (psel && penable && !pready);
  c_irq: cover property ($rose(irq));
  c_busy: cover property (st_rd && sync_age == 0);
endmodule

// ==== testbench/uarx_top_tb.sv ====
// self-checking bench for the serial port: bus, parity, irq, sleep and sync
`timescale 1ns/1ps
`include "uarx_defines.vh"
module uarx_top_tb;
  localparam logic [31:0] CA = 4 * `UARX_IDX_CONTROL_A;
  localparam logic [31:0] CB = 4 * `UARX_IDX_CONTROL_B;
  localparam logic [31:0] ST = 4 * `UARX_IDX_STATUS;
  localparam logic [31:0] FL = 4 * `UARX_IDX_IRQ_FLAGS;
  localparam logic [31:0] DT = 4 * `UARX_IDX_DATA;
  localparam logic [31:0] ISET = 4 * `UARX_IDX_IRQ_SET;
  // internal clock, parity frame, lsb first
  localparam logic [31:0] CFG = 32'h4100_0004;
  localparam logic [31:0] RXTX = 32'h0003_0000;
  localparam logic [7:0]  TXV = 8'h34;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        sleep_active;
  logic        serr;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] rd_q;
  wire  [31:0] prdata;
  wire         pready, pslverr, rxd, txd, core_clock_run, wake_request, irq;
  int          err_total, num_checks, waits;
  always #2.5 pclk = ~pclk;
  uarx_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .rxd, .txd, .sleep_active, .core_clock_run, .wake_request, .irq);
  uarx_remote rem (.txd, .rxd);
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // caller sits just after a rising edge; request held until pready
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    waits = 0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      waits++;
      @(posedge pclk);
    end
    serr = pslverr;
    rd_q = prdata;
  endtask
  task rel;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    rel;
  endtask
  task rd(input logic [31:0] a);
    apb(1'b0, a, 32'h0);
    rel;
  endtask
  task bit1(input string nm, input logic v, input logic e);
    chk(nm, {31'h0, v}, {31'h0, e});
  endtask
  // disable, program, then enable right behind the config write
  task cfg(input logic [31:0] ca, input logic [31:0] cb);
    wr(CA, ca);
    wr(CB, cb);
    apb(1'b1, CA, ca);
    apb(1'b1, CA, ca | 32'h2);
    bit1("stall", waits > 0, 1'b1);
    apb(1'b0, ST, 32'h0);
    bit1("busy", rd_q[15], 1'b1);
    rel;
    rd(CA);
    chk("ctrl_a", rd_q, ca | 32'h2);
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    tk(60000);
    err_total++;
    wrap_up;
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, sleep_active} = 6'h00;
    {paddr, pwdata, err_total, num_checks} = 0;
    tk(20);
    presetn <= 1'b1;
    tk(1);
    bit1("irq", irq, 1'b0);
    rd(CA);
    chk("ctrl_a", rd_q, `UARX_RESET_WORD);
    rd(32'h14);
    bit1("slverr", serr, 1'b1);
    wr(4 * `UARX_IDX_BAUD, 32'h0000_C000);
    wr(ISET, 32'h4);
    wr(ISET, 32'h0);
    rd(ISET);
    chk("irq_en", rd_q, 32'h4);
    for (int pm = 0; pm < 2; pm++) begin
      cfg(CFG, RXTX | (pm << 13));
      wr(DT, {24'h0, TXV});
      wait (rem.got_cnt == pm + 1);
      tk(80);
      chk("tx_data", {24'h0, rem.got_data}, {24'h0, TXV});
      bit1("tx_par", rem.got_par, ^TXV ^ pm[0]);
      rd(FL);
      chk("flags", rd_q, 32'h3);
      wr(FL, 32'h2);
      rd(FL);
      chk("flags", rd_q, 32'h1);
      rem.send(TXV, 1'b1, ^TXV ^ pm[0], 1'b1, 320.0);
      tk(4);
      bit1("irq", irq, 1'b1);
      rd(DT);
      chk("data", rd_q, {24'h0, TXV});
      bit1("irq", irq, 1'b0);
      rem.send(TXV, 1'b1, ~(^TXV ^ pm[0]), 1'b1, 320.0);
      tk(4);
      rd(ST);
      chk("status", rd_q, 32'h1);
      wr(ST, 32'h1);
      rd(ST);
      chk("status", rd_q, 32'h0);
      rd(DT);
    end
    // odd parity still set; all bytes below have four ones
    rem.send(8'hA5, 1'b1, 1'b1, 1'b0, 320.0);
    rem.send(8'h5A, 1'b1, 1'b1, 1'b1, 329.9);
    tk(4);
    rd(ST);
    chk("status", rd_q, 32'h2);
    rd(DT);
    chk("data", rd_q, 32'hA5);
    rd(DT);
    chk("data", rd_q, 32'h5A);
    rem.send(8'hC3, 1'b1, 1'b1, 1'b1, 307.7);
    tk(4);
    rd(DT);
    chk("data", rd_q, 32'hC3);
    repeat (3) rem.send(8'hA5, 1'b1, 1'b1, 1'b1, 320.0);
    tk(4);
    rd(ST);
    chk("status", rd_q, 32'h6);
    wr(CB, 32'h0001_2000);
    tk(8);
    rd(ST);
    chk("status", rd_q, 32'h0);
    wr(4 * `UARX_IDX_IRQ_CLR, 32'h7);
    sleep_active <= 1'b1;
    tk(4);
    bit1("clk_run", core_clock_run, 1'b0);
    sleep_active <= 1'b0;
    cfg(CFG | 32'h80, RXTX | 32'h2000);
    wr(ISET, 32'h4);
    sleep_active <= 1'b1;
    tk(4);
    bit1("clk_run", core_clock_run, 1'b1);
    rem.send(8'h5A, 1'b1, 1'b1, 1'b1, 320.0);
    tk(4);
    bit1("wake", wake_request, 1'b1);
    wrap_up;
  end
endmodule
bind uarx_top uarx_top_properties #(.SYNC_CYCLES(SYNC_CYCLES)) u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .irq);
